/* File: inc/hbpmc_pkg.sv */
// Constants and types shared by the half-bridge PWM mode control block
// How it works
// - Logic-supply power-on clears configuration, outputs off
// - Load-supply dropout keeps configuration, resumes afterwards
// - Enable high: normal mode, charge pump, configurable
// - Enable low: sleep, outputs off, registers reset
// - Logic supply low: no bus, cleared, off
// - Reset-occurred flag reads 0 after supply recovery
// - Enable-pin reset also reported by flag zero
// - Continuous or PWM drive per half-bridge, chosen for both sides together
// - Three channels, each with own 8-bit duty
// - Frequency codes 01/10/11 give 80/100/200 Hz
// - Frequency and duty changes apply glitch-free
// - Free-wheel active or passive, passive after reset
// - Two-bit channel assign per bridge, 00 none
// - PWM low side, active free-wheel: high side fills
// - Frequency code 00 stops channel, output off
// - Stopped channel, active free-wheel: the side opposite the enabled one on
package hbpmc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int NUM_BRIDGES = 8;
  localparam int NUM_CHANNELS = 3;
  localparam int DUTY_W = 8;
  localparam int IRQ_W = 5;

  localparam logic [ADDR_W-1:0] ADDR_ACTIVATION = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_ASSIGN = 8'h01;
  localparam logic [ADDR_W-1:0] ADDR_FREQ = 8'h02;
  localparam logic [ADDR_W-1:0] ADDR_DECAY = 8'h03;
  localparam logic [ADDR_W-1:0] ADDR_DUTY_BASE = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h07;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'h09;

  localparam logic [15:0] RST_ACTIVATION = 16'h0000;
  localparam logic [15:0] RST_ASSIGN = 16'h0000;
  localparam logic [5:0] RST_FREQ = 6'h00;
  localparam logic [7:0] RST_DECAY = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [4:0] RST_IRQ = 5'h00;

  localparam int STATUS_FLAG_BIT = 0;
  localparam int STATUS_LOAD_OK_BIT = 1;
  localparam int STATUS_PUMP_BIT = 2;
  localparam int IRQ_PERIOD_LSB = 0;
  localparam int IRQ_LOAD_DROP_BIT = 3;
  localparam int IRQ_LOAD_BACK_BIT = 4;

  typedef enum logic [1:0] {
    FREQ_STOP = 2'b00,
    FREQ_80 = 2'b01,
    FREQ_100 = 2'b10,
    FREQ_200 = 2'b11
  } hbpmc_freq_t;

  localparam int CLK_HZ = 25_000_000;
  localparam int PWM_STEPS = 256;
  localparam int FREQ_80_HZ = 80;
  localparam int FREQ_100_HZ = 100;
  localparam int FREQ_200_HZ = 200;
  localparam int TICK_W = 11;
  localparam logic [TICK_W-1:0] TICK_LAST_80 = TICK_W'(CLK_HZ / (PWM_STEPS * FREQ_80_HZ) - 1);
  localparam logic [TICK_W-1:0] TICK_LAST_100 = TICK_W'(CLK_HZ / (PWM_STEPS * FREQ_100_HZ) - 1);
  localparam logic [TICK_W-1:0] TICK_LAST_200 = TICK_W'(CLK_HZ / (PWM_STEPS * FREQ_200_HZ) - 1);

endpackage

/* File: logic/hbpmc_bridge.sv */
// Maps activation, channel assignment and free-wheel onto the eight output stages
`timescale 1ns/1ns
`default_nettype none
module hbpmc_bridge
  import hbpmc_pkg::*;
#(
  parameter int BRIDGES = NUM_BRIDGES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic drive_ok,
  input wire logic [2*BRIDGES-1:0] activation,
  input wire logic [2*BRIDGES-1:0] channel_assign,
  input wire logic [BRIDGES-1:0] decay_active,
  input wire logic [NUM_CHANNELS-1:0] chan_on,
  output logic [BRIDGES-1:0] high_side_switch,
  output logic [BRIDGES-1:0] low_side_switch
);

  // Index 0 stands for no channel: full on while the side is enabled
  wire logic [3:0] level_by_sel;
  assign level_by_sel = {chan_on, 1'b1};

  for (genvar i = 0; i < BRIDGES; i++) begin : g_bridge
    wire logic [1:0] sel;
    wire logic pwm_used;
    wire logic pwm_level;
    wire logic hs_en;
    wire logic ls_en;
    wire logic fill;
    wire logic hs_next;
    wire logic ls_next;
    assign sel = channel_assign[2*i +: 2];
    assign pwm_used = sel != 2'b00;
    assign pwm_level = level_by_sel[sel];
    assign hs_en = activation[2*i];
    assign ls_en = activation[2*i+1];
    // With active free-wheel the opposite side conducts in the off phase; a stopped channel is all off phase
    assign fill = decay_active[i] && pwm_used && !pwm_level;
    // Both sides enabled would short the supply, so both stay off
    assign hs_next = drive_ok && !(hs_en && ls_en) &&
                     ((hs_en && pwm_level) || (ls_en && fill));
    assign ls_next = drive_ok && !(hs_en && ls_en) &&
                     ((ls_en && pwm_level) || (hs_en && fill));
    always_ff @(posedge sys_clk) begin
      if (rst) begin
        high_side_switch[i] <= 1'b0;
        low_side_switch[i] <= 1'b0;
      end else begin
        high_side_switch[i] <= hs_next;
        low_side_switch[i] <= ls_next;
      end
    end
  end

endmodule
`default_nettype wire

/* File: logic/hbpmc_channel.sv */
// One PWM channel: shadowed frequency and duty, phase counter, output level
`timescale 1ns/1ns
`default_nettype none
module hbpmc_channel
  import hbpmc_pkg::*;
#(
  parameter int CH_DUTY_W = DUTY_W
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [1:0] freq_code,
  input wire logic [CH_DUTY_W-1:0] duty,
  output logic pwm_on,
  output logic period_start
);

  logic [1:0] freq_reg;
  logic [CH_DUTY_W-1:0] duty_reg;
  logic [CH_DUTY_W-1:0] phase_reg;
  logic [TICK_W-1:0] tick_reg;

  wire logic [TICK_W-1:0] tick_last;
  wire logic tick_wrap;
  wire logic running;
  wire logic period_end;

  assign tick_last = (freq_reg == FREQ_80) ? TICK_LAST_80 :
                     (freq_reg == FREQ_100) ? TICK_LAST_100 : TICK_LAST_200;
  assign tick_wrap = tick_reg == tick_last;
  assign running = freq_reg != FREQ_STOP;
  // A stopped channel takes new settings at once; a running one only at wrap
  assign period_end = !running || (tick_wrap && (&phase_reg));

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      freq_reg <= FREQ_STOP;
      duty_reg <= '0;
      phase_reg <= '0;
      tick_reg <= '0;
      pwm_on <= 1'b0;
      period_start <= 1'b0;
    end else begin
      if (period_end) begin
        freq_reg <= freq_code;
        duty_reg <= duty;
        phase_reg <= '0;
        tick_reg <= '0;
      end else begin
        tick_reg <= tick_wrap ? '0 : TICK_W'(tick_reg + 1'b1);
        phase_reg <= CH_DUTY_W'(phase_reg + CH_DUTY_W'(tick_wrap));
      end
      pwm_on <= running && (phase_reg < duty_reg);
      period_start <= period_end && (freq_code != FREQ_STOP);
    end
  end

endmodule
`default_nettype wire

/* File: logic/hbpmc_top.sv */
// Top of the half-bridge PWM mode control: modes, resets, registers, interrupt
`timescale 1ns/1ns
`default_nettype none
module hbpmc_top
  import hbpmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic logic_supply_ok,
  input wire logic load_supply_ok,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DATA_W-1:0] reg_rdata,
  output logic irq,
  output logic charge_pump_on,
  output logic [NUM_BRIDGES-1:0] high_side_switch,
  output logic [NUM_BRIDGES-1:0] low_side_switch
);

  // Logic-supply loss, power-on and enable low all clear the logic alike
  wire logic logic_rst;
  assign logic_rst = reset || !logic_supply_ok || !enable_pin;

  // Bus is dead while the logic supply is low or the device sleeps
  wire logic bus_live;
  assign bus_live = logic_supply_ok && enable_pin;

  wire logic wr_en;
  wire logic rd_en;
  assign wr_en = reg_write && bus_live && !reset;
  assign rd_en = reg_read && bus_live && !reset;

  wire logic hit_act;
  wire logic hit_assign;
  wire logic hit_freq;
  wire logic hit_decay;
  wire logic hit_status;
  wire logic hit_irq_status;
  wire logic hit_irq_mask;
  assign hit_act = reg_addr == ADDR_ACTIVATION;
  assign hit_assign = reg_addr == ADDR_ASSIGN;
  assign hit_freq = reg_addr == ADDR_FREQ;
  assign hit_decay = reg_addr == ADDR_DECAY;
  assign hit_status = reg_addr == ADDR_STATUS;
  assign hit_irq_status = reg_addr == ADDR_IRQ_STATUS;
  assign hit_irq_mask = reg_addr == ADDR_IRQ_MASK;

  // Configuration registers
  logic [2*NUM_BRIDGES-1:0] bridge_activation_ctrl_reg;
  logic [2*NUM_BRIDGES-1:0] bridge_channel_assign_reg;
  logic [2*NUM_CHANNELS-1:0] pwm_frequency_select_reg;
  logic [NUM_BRIDGES-1:0] decay_path_mode_reg;
  logic [DUTY_W-1:0] duty_reg [NUM_CHANNELS];
  logic reset_occurred_flag_n_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_status_next;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic load_ok_reg;

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      bridge_activation_ctrl_reg <= RST_ACTIVATION;
      bridge_channel_assign_reg <= RST_ASSIGN;
      pwm_frequency_select_reg <= RST_FREQ;
      decay_path_mode_reg <= RST_DECAY;
    end else if (wr_en) begin
      if (hit_act) begin
        bridge_activation_ctrl_reg <= reg_wdata;
      end
      if (hit_assign) begin
        bridge_channel_assign_reg <= reg_wdata;
      end
      if (hit_freq) begin
        pwm_frequency_select_reg <= reg_wdata[2*NUM_CHANNELS-1:0];
      end
      if (hit_decay) begin
        decay_path_mode_reg <= reg_wdata[NUM_BRIDGES-1:0];
      end
    end
  end

  // Duty registers and channels, one per PWM channel
  wire logic [NUM_CHANNELS-1:0] chan_on;
  wire logic [NUM_CHANNELS-1:0] chan_period;

  for (genvar c = 0; c < NUM_CHANNELS; c++) begin : g_chan
    wire logic hit_duty;
    assign hit_duty = reg_addr == ADDR_DUTY_BASE + ADDR_W'(c);
    always_ff @(posedge sys_clk) begin
      if (logic_rst) begin
        duty_reg[c] <= RST_DUTY;
      end else if (wr_en && hit_duty) begin
        duty_reg[c] <= reg_wdata[DUTY_W-1:0];
      end
    end
    hbpmc_channel #(
      .CH_DUTY_W(DUTY_W)
    ) u_chan (
      .sys_clk(sys_clk),
      .rst(logic_rst),
      .freq_code(pwm_frequency_select_reg[2*c +: 2]),
      .duty(duty_reg[c]),
      .pwm_on(chan_on[c]),
      .period_start(chan_period[c])
    );
  end

  // Flag reads zero after every reset until software writes a one to it
  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      reset_occurred_flag_n_reg <= 1'b0;
    end else if (wr_en && hit_status && reg_wdata[STATUS_FLAG_BIT]) begin
      reset_occurred_flag_n_reg <= 1'b1;
    end
  end

  // Load supply gates the stages and raises events; stored settings are untouched
  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      // Healthy level, so no false return event follows reset
      load_ok_reg <= 1'b1;
    end else begin
      load_ok_reg <= load_supply_ok;
    end
  end

  wire logic load_drop;
  wire logic load_back;
  assign load_drop = load_ok_reg && !load_supply_ok;
  assign load_back = !load_ok_reg && load_supply_ok;

  // Sticky events: a new event wins over a write-one clear in the same cycle
  wire logic [IRQ_W-1:0] irq_events;
  wire logic [IRQ_W-1:0] irq_clear;
  assign irq_events = {load_back, load_drop, chan_period};
  assign irq_clear = (wr_en && hit_irq_status) ? reg_wdata[IRQ_W-1:0] : '0;
  assign irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      irq_status_reg <= RST_IRQ;
      irq_mask_reg <= RST_IRQ;
      irq <= 1'b0;
    end else begin
      irq_status_reg <= irq_status_next;
      if (wr_en && hit_irq_mask) begin
        irq_mask_reg <= reg_wdata[IRQ_W-1:0];
      end
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Output stages: off in sleep, below logic supply or with the load supply gone
  wire logic drive_ok;
  assign drive_ok = load_supply_ok;

  hbpmc_bridge #(
    .BRIDGES(NUM_BRIDGES)
  ) u_bridge (
    .sys_clk(sys_clk),
    .rst(logic_rst),
    .drive_ok(drive_ok),
    .activation(bridge_activation_ctrl_reg),
    .channel_assign(bridge_channel_assign_reg),
    .decay_active(decay_path_mode_reg),
    .chan_on(chan_on),
    .high_side_switch(high_side_switch),
    .low_side_switch(low_side_switch)
  );

  always_ff @(posedge sys_clk) begin
    if (logic_rst) begin
      charge_pump_on <= 1'b0;
    end else begin
      charge_pump_on <= 1'b1;
    end
  end

  // Read-back mux; unmapped addresses read zero
  wire logic [DATA_W-1:0] global_status_one;
  assign global_status_one = DATA_W'({charge_pump_on, load_ok_reg, reset_occurred_flag_n_reg});

  wire logic [2:0] duty_idx;
  wire logic hit_duty_any;
  assign duty_idx = 3'(reg_addr - ADDR_DUTY_BASE);
  assign hit_duty_any = (reg_addr >= ADDR_DUTY_BASE) &&
                        (reg_addr < ADDR_DUTY_BASE + ADDR_W'(NUM_CHANNELS));

  wire logic [DATA_W-1:0] rd_mux;
  assign rd_mux = hit_act ? bridge_activation_ctrl_reg :
                  hit_assign ? bridge_channel_assign_reg :
                  hit_freq ? DATA_W'(pwm_frequency_select_reg) :
                  hit_decay ? DATA_W'(decay_path_mode_reg) :
                  hit_duty_any ? DATA_W'(duty_reg[duty_idx[1:0]]) :
                  hit_status ? global_status_one :
                  hit_irq_status ? DATA_W'(irq_status_reg) :
                  hit_irq_mask ? DATA_W'(irq_mask_reg) : '0;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rd_en ? rd_mux : '0;
    end
  end

endmodule
`default_nettype wire

/* File: sim/hbpmc_checker.sv */
// Port-level assertions for the half-bridge PWM mode control top
`timescale 1ns/1ns
`default_nettype none
module hbpmc_checker
  import hbpmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic enable_pin,
  input wire logic logic_supply_ok,
  input wire logic load_supply_ok,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic irq,
  input wire logic charge_pump_on,
  input wire logic [NUM_BRIDGES-1:0] high_side_switch,
  input wire logic [NUM_BRIDGES-1:0] low_side_switch
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire logic all_off = (high_side_switch | low_side_switch) == '0;
  wire logic quiet = all_off && !irq && !charge_pump_on;
  wire logic live = enable_pin && logic_supply_ok;
  sequence s_sleep;
    !enable_pin;
  endsequence
  sequence s_wake;
    !enable_pin ##1 live;
  endsequence
  sleep_off_a: assert property (s_sleep |=> quiet)
    else $error("outputs active in sleep");
  supply_off_a: assert property (!logic_supply_ok |=> all_off && !charge_pump_on)
    else $error("outputs active with logic supply low");
  bus_dead_a: assert property (reg_read && !live |=> reg_rdata == '0)
    else $error("read answered while inactive");
  pump_run_a: assert property (!reset && live |=> charge_pump_on)
    else $error("charge pump off in normal mode");
  wake_clean_a: assert property (s_wake |=> charge_pump_on && all_off)
    else $error("wake not clean");
  load_gate_a: assert property (!load_supply_ok |=> all_off)
    else $error("switch on without load supply");
  no_cross_a: assert property ((high_side_switch & low_side_switch) == '0)
    else $error("both sides of a bridge on");
  por_clear_a: assert property ($fell(reset) |-> quiet && reg_rdata == '0)
    else $error("state not cleared by power-on");
endmodule
bind hbpmc_top hbpmc_checker u_chk (.sys_clk, .reset, .enable_pin, .logic_supply_ok,
  .load_supply_ok, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq,
  .charge_pump_on, .high_side_switch, .low_side_switch);
`default_nettype wire

/* File: sim/hbpmc_host.sv */
// Host model driving the register bus of the block
`timescale 1ns/1ns
`default_nettype none
module hbpmc_host
  import hbpmc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [DATA_W-1:0] reg_rdata,
  output logic [ADDR_W-1:0] reg_addr,
  output logic [DATA_W-1:0] reg_wdata,
  output logic reg_write,
  output logic reg_read
);
  initial begin
    reg_addr = '0;
    reg_wdata = '0;
    reg_write = 1'b0;
    reg_read = 1'b0;
  end
  // Idle address shows the inverse of the last transfer, idle data the inverse of the last write
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    @(posedge sys_clk);
    d = reg_rdata;
  endtask
  // Channel stays stopped while configured; the caller starts it
  task automatic prep(input logic [15:0] fw, input logic [15:0] asg,
      input logic [15:0] act, input logic [7:0] d1, input logic [7:0] d2,
      input logic [7:0] d3);
    wr(ADDR_FREQ, 16'h0000);
    wr(ADDR_DECAY, fw);
    wr(ADDR_ASSIGN, asg);
    wr(ADDR_DUTY_BASE, {8'h00, d1});
    wr(ADDR_DUTY_BASE + 8'h01, {8'h00, d2});
    wr(ADDR_DUTY_BASE + 8'h02, {8'h00, d3});
    wr(ADDR_ACTIVATION, act);
  endtask
endmodule
`default_nettype wire

/* File: sim/hbpmc_top_tb.sv */
// Self-checking bench for the half-bridge PWM mode control top
`timescale 1ns/1ns
`default_nettype none
module hbpmc_top_tb
  import hbpmc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic enable_pin = 1'b1;
  logic logic_supply_ok = 1'b1;
  logic load_supply_ok = 1'b1;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_rdata;
  logic reg_write, reg_read, irq, charge_pump_on;
  logic [NUM_BRIDGES-1:0] high_side_switch, low_side_switch;
  logic [7:0] adr [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06};
  int err_count = 0;
  int checks_done = 0;
  int cyc = 0;
  hbpmc_top u_dut (.sys_clk, .reset, .enable_pin, .logic_supply_ok, .load_supply_ok,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq, .charge_pump_on,
    .high_side_switch, .low_side_switch);
  hbpmc_host u_host (.sys_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_write, .reg_read);
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cnt(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic pins(input logic [7:0] hs, input logic [7:0] ls);
    chk("high_side", {8'h00, hs}, {8'h00, high_side_switch});
    chk("low_side", {8'h00, ls}, {8'h00, low_side_switch});
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    u_host.rd(a, d);
    chk("rdata", e, d);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  function automatic int on_len(input int d, input int c);
    int hz;
    hz = (c == 1) ? FREQ_80_HZ : (c == 2) ? FREQ_100_HZ : FREQ_200_HZ;
    return d * (CLK_HZ / (PWM_STEPS * hz));
  endfunction
  function automatic logic [15:0] rmask(input logic [7:0] a);
    return (a <= ADDR_ASSIGN) ? 16'hffff : 16'h00ff;
  endfunction
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    logic [7:0] a;
    logic [15:0] d;
    logic [7:0] dt [3];
    logic [31:0] n [4];
    void'($urandom(12));
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    for (int k = 0; k < 7; k++) rdchk(8'(k), 16'h0000);
    rdchk(ADDR_STATUS, 16'h0006);
    u_host.wr(ADDR_STATUS, 16'h0001);
    rdchk(ADDR_STATUS, 16'h0007);
    for (int k = 0; k < 12; k++) begin
      a = adr[$urandom % 6];
      d = 16'($urandom);
      u_host.wr(a, d);
      rdchk(a, d & rmask(a));
    end
    u_host.wr(8'h20, 16'hffff);
    rdchk(8'h20, 16'h0000);
    enable_pin <= 1'b0;
    rdchk(ADDR_STATUS, 16'h0000);
    enable_pin <= 1'b1;
    for (int k = 0; k < 7; k++) rdchk(8'(k), 16'h0000);
    rdchk(ADDR_STATUS, 16'h0006);
    u_host.wr(ADDR_STATUS, 16'h0001);
    logic_supply_ok <= 1'b0;
    rdchk(ADDR_STATUS, 16'h0000);
    logic_supply_ok <= 1'b1;
    rdchk(ADDR_STATUS, 16'h0006);
    u_host.wr(ADDR_ACTIVATION, 16'h0009);
    u_host.wr(ADDR_IRQ_MASK, 16'h0008);
    repeat (2) @(posedge sys_clk);
    pins(8'h01, 8'h02);
    load_supply_ok <= 1'b0;
    repeat (4) @(posedge sys_clk);
    pins(8'h00, 8'h00);
    chk("irq", 16'h0001, 16'(irq));
    load_supply_ok <= 1'b1;
    repeat (4) @(posedge sys_clk);
    pins(8'h01, 8'h02);
    rdchk(ADDR_IRQ_STATUS, 16'h0018);
    u_host.wr(ADDR_IRQ_STATUS, 16'h0008);
    repeat (2) @(posedge sys_clk);
    chk("irq", 16'h0000, 16'(irq));
    rdchk(ADDR_IRQ_STATUS, 16'h0010);
    for (int k = 0; k < 3; k++) dt[k] = 8'(1 + $urandom % 3);
    // Low sides of bridges 0..2 on channels 1..3, high side of bridge 3 on channel 1
    u_host.prep(16'h000f, 16'h0079, 16'h006a, dt[0], dt[1], dt[2]);
    repeat (3) @(posedge sys_clk);
    pins(8'h07, 8'h08);
    u_host.wr(ADDR_FREQ, 16'h0039);
    u_host.wr(ADDR_DUTY_BASE + 8'h02, 16'h00ff);
    n = '{default: '0};
    repeat (4000) begin
      @(posedge sys_clk);
      for (int k = 0; k < 3; k++) n[k] = n[k] + 32'(low_side_switch[k]);
      n[3] = n[3] + 32'(high_side_switch[3]);
    end
    for (int k = 0; k < 4; k++) begin
      chk_cnt("on_time", on_len(dt[k % 3], k % 3 + 1), n[k]);
    end
    pins(8'h07, 8'h08);
    rdchk(ADDR_IRQ_STATUS, 16'h0017);
    // Passive free-wheel: the off phase leaves both sides off
    u_host.wr(ADDR_DECAY, 16'h0000);
    repeat (2) @(posedge sys_clk);
    pins(8'h00, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
